// ---- inc/dma_cfg.svh ----
// Named constants for the multichannel DMA controller
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH

// Channel population: peripheral channels first, then memory channels
`define DMA_NCH 4
`define DMA_NPER 2
`define DMA_NEXT 2

// Register port decode: word address, channel field, register field
`define DMA_ADDR_W 8
`define DMA_GLOBAL_BIT 7
`define DMA_SPARE_BIT 6
`define DMA_CH_HI 5
`define DMA_CH_LO 4
`define DMA_OFF_HI 3

// Per-channel register offsets
`define DMA_R_CFG 4'h0
`define DMA_R_SRC_START 4'h1
`define DMA_R_SRC_XMOD 4'h2
`define DMA_R_SRC_YMOD 4'h3
`define DMA_R_DST_START 4'h4
`define DMA_R_DST_XMOD 4'h5
`define DMA_R_DST_YMOD 4'h6
`define DMA_R_XCNT 4'h7
`define DMA_R_YCNT 4'h8
`define DMA_R_NEXT 4'h9
`define DMA_R_POS 4'hA
`define DMA_R_CUR_SRC 4'hB
`define DMA_R_CUR_DST 4'hC

// Global register offsets
`define DMA_G_IRQ_ST 8'h80
`define DMA_G_IRQ_MASK 8'h81
`define DMA_G_EXT 8'h82

// External request control fields
`define DMA_EXT_CNT_HI 7
`define DMA_EXT_EN_LO 8
`define DMA_EXT_EN_HI 9
`define DMA_EXT_PRIO_BIT 10

// Channel mode codes
`define DMA_MODE_STOP 2'h0
`define DMA_MODE_AUTO 2'h1
`define DMA_MODE_LIST 2'h2
`define DMA_MODE_ARRAY 2'h3

// Descriptor layout: last word index per descriptor, word index of each field
`define DMA_LIST_LAST 3'h5
`define DMA_ARRAY_LAST 3'h0
`define DMA_D_NEXT 3'h0
`define DMA_D_SRC 3'h1
`define DMA_D_DST 3'h2
`define DMA_D_CNT 3'h3
`define DMA_D_SMOD 3'h4
`define DMA_D_DMOD 3'h5

// Sizes and reset values
`define DMA_CNT_W 16
`define DMA_CREDIT_W 16
`define DMA_CNT_ONE 16'h0001
`define DMA_WORD_BYTES 32'h00000004
`define DMA_ELEM_PAD 2'h0
`define DMA_ZERO32 32'h00000000

`endif

// ---- inc/dma_pkg.sv ----
// Types shared by the DMA controller modules
`include "dma_cfg.svh"
package dma_pkg;

    // Per-channel configuration word
    typedef struct packed {
        logic use_req;
        logic row_irq;
        logic two_d;
        logic [1:0] mode;
        logic en;
    } ch_cfg_t;

    // Command to the memory side
    typedef struct packed {
        logic valid;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_cmd_t;

    typedef logic [1:0] ch_idx_t;

    // Shared transfer engine
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DESC,
        ST_LOAD,
        ST_RD,
        ST_WR,
        ST_STEP
    } eng_state_t;

endpackage

// ---- core/dma_addr_gen.sv ----
// Address generator: start load and signed element step
`timescale 1ns/10ps
`include "dma_cfg.svh"
module dma_addr_gen (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [31:0] start_addr,
    input wire logic step,
    input wire logic [15:0] step_mod,
    output logic [31:0] addr
);

    // Step is in elements; scaled to bytes, sign kept for negative strides
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr <= `DMA_ZERO32;
        end else if (load) begin
            addr <= start_addr;
        end else if (step) begin
            addr <= addr + {{14{step_mod[15]}}, step_mod, `DMA_ELEM_PAD};
        end
    end

endmodule // dma_addr_gen

// ---- core/dma_ctrl.sv ----
// Multichannel DMA controller: registers, channel sequencing, shared engine
`timescale 1ns/10ps
`include "dma_cfg.svh"
module dma_ctrl
    import dma_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output mem_cmd_t mem_cmd,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic [1:0] periph_req,
    output logic [1:0] periph_done,
    input wire logic [1:0] ext_dma_req,
    output logic ext_prio,
    output logic irq
);

    // Channel parameter registers
    ch_cfg_t cfg_q [`DMA_NCH];
    logic [31:0] src_start_q [`DMA_NCH];
    logic [31:0] dst_start_q [`DMA_NCH];
    logic [15:0] src_xmod_q [`DMA_NCH];
    logic [15:0] src_ymod_q [`DMA_NCH];
    logic [15:0] dst_xmod_q [`DMA_NCH];
    logic [15:0] dst_ymod_q [`DMA_NCH];
    logic [`DMA_CNT_W-1:0] xcnt_q [`DMA_NCH];
    logic [`DMA_CNT_W-1:0] ycnt_q [`DMA_NCH];
    logic [31:0] next_q [`DMA_NCH];

    // Channel run state
    logic [`DMA_NCH-1:0] run_q;
    logic [`DMA_NCH-1:0] need_q;
    logic [`DMA_CNT_W-1:0] xpos_q [`DMA_NCH];
    logic [`DMA_CNT_W-1:0] ypos_q [`DMA_NCH];

    // Engine state
    eng_state_t state_q;
    ch_idx_t act_q;
    logic [2:0] didx_q;
    logic [31:0] dptr_q;
    mem_cmd_t mem_cmd_q;

    // Interrupt, external request and priority state
    logic [`DMA_NCH-1:0] irq_st_q;
    logic [`DMA_NCH-1:0] irq_st_d;
    logic [`DMA_NCH-1:0] irq_mask_q;
    logic irq_q;
    logic [7:0] per_edge_q;
    logic [1:0] ext_en_q;
    logic prio_q;
    logic ext_prio_q;
    logic [1:0] ext_prev_q;
    logic [`DMA_CREDIT_W-1:0] credit_q [`DMA_NEXT];
    logic [1:0] periph_done_q;
    logic [31:0] rdata_q;

    // Per-channel combinational terms
    logic [31:0] src_addr [`DMA_NCH];
    logic [31:0] dst_addr [`DMA_NCH];
    logic [`DMA_NCH-1:0] permit;
    logic [`DMA_NCH-1:0] want;
    logic [`DMA_NCH-1:0] load_c;
    logic [`DMA_NCH-1:0] step_c;
    logic [`DMA_NCH-1:0] wr_cfg;
    logic [`DMA_NCH-1:0] irq_set;
    logic [1:0] ext_edge;

    // Decode and active-channel terms
    logic reg_is_ch;
    ch_idx_t reg_ch;
    logic [3:0] reg_off;
    ch_cfg_t act_cfg;
    logic row_end;
    logic buf_end;
    logic in_step;
    logic [2:0] desc_last;
    ch_idx_t pick;
    logic pick_ok;

    assign reg_is_ch = ~reg_addr[`DMA_GLOBAL_BIT] & ~reg_addr[`DMA_SPARE_BIT];
    assign reg_ch = reg_addr[`DMA_CH_HI:`DMA_CH_LO];
    assign reg_off = reg_addr[`DMA_OFF_HI:0];

    // Element position of the channel the engine is serving
    assign act_cfg = cfg_q[act_q];
    assign row_end = (xpos_q[act_q] == xcnt_q[act_q]);
    assign buf_end = row_end & (~act_cfg.two_d | (ypos_q[act_q] == ycnt_q[act_q]));
    assign in_step = (state_q == ST_STEP);
    assign desc_last = (act_cfg.mode == `DMA_MODE_ARRAY) ? `DMA_ARRAY_LAST : `DMA_LIST_LAST;
    assign ext_edge = ext_dma_req & ~ext_prev_q & ext_en_q;

    // Per-channel address generators and sequencing terms
    genvar c;
    generate
        for (c = 0; c < `DMA_NCH; c++) begin : g_ch
            logic act_here;
            logic [15:0] src_mod;
            logic [15:0] dst_mod;
            assign act_here = (act_q == ch_idx_t'(c));
            assign wr_cfg[c] = reg_wr & reg_is_ch & (reg_ch == ch_idx_t'(c)) &
                               (reg_off == `DMA_R_CFG);
            // Register start in stop/auto mode, descriptor apply, or auto reload
            assign load_c[c] = (wr_cfg[c] & reg_wdata[0] & ~reg_wdata[2]) |
                               ((state_q == ST_LOAD) & act_here) |
                               (in_step & act_here & buf_end &
                                (cfg_q[c].mode == `DMA_MODE_AUTO));
            assign step_c[c] = in_step & act_here & ~load_c[c];
            // Outer stride replaces the inner one at a row end in 2-D mode; any signed value
            assign src_mod = (row_end & cfg_q[c].two_d) ? src_ymod_q[c] : src_xmod_q[c];
            assign dst_mod = (row_end & cfg_q[c].two_d) ? dst_ymod_q[c] : dst_xmod_q[c];
            assign irq_set[c] = in_step & act_here &
                                (buf_end | (cfg_q[c].row_irq & cfg_q[c].two_d & row_end));
            if (c < `DMA_NPER) begin : g_per
                // Dedicated channel paced by its own peripheral request
                assign permit[c] = ~cfg_q[c].use_req | periph_req[c];
            end else begin : g_mem
                // Memory channel, free running or paced by external credits
                assign permit[c] = ~cfg_q[c].use_req | (|credit_q[c-`DMA_NPER]);
            end
            assign want[c] = run_q[c] & (need_q[c] | permit[c]);
            dma_addr_gen u_src (
                .clk(clk),
                .reset_n(reset_n),
                .load(load_c[c]),
                .start_addr(src_start_q[c]),
                .step(step_c[c]),
                .step_mod(src_mod),
                .addr(src_addr[c])
            );
            dma_addr_gen u_dst (
                .clk(clk),
                .reset_n(reset_n),
                .load(load_c[c]),
                .start_addr(dst_start_q[c]),
                .step(step_c[c]),
                .step_mod(dst_mod),
                .addr(dst_addr[c])
            );
        end
    endgenerate

    // Arbiter: lowest channel wins; priority bit lifts memory channels first
    always_comb begin
        pick = '0;
        pick_ok = 1'b0;
        for (int i = `DMA_NCH - 1; i >= 0; i--) begin
            if (want[i]) begin
                pick = ch_idx_t'(i);
                pick_ok = 1'b1;
            end
        end
        if (prio_q) begin
            for (int i = `DMA_NCH - 1; i >= `DMA_NPER; i--) begin
                if (want[i]) begin
                    pick = ch_idx_t'(i);
                    pick_ok = 1'b1;
                end
            end
        end
    end

    // Shared engine: one element is a read then a write on the memory side
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            act_q <= '0;
            didx_q <= '0;
            dptr_q <= `DMA_ZERO32;
            mem_cmd_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (pick_ok) begin
                        act_q <= pick;
                        mem_cmd_q.valid <= 1'b1;
                        mem_cmd_q.we <= 1'b0;
                        if (need_q[pick]) begin
                            state_q <= ST_DESC;
                            didx_q <= '0;
                            dptr_q <= next_q[pick];
                            mem_cmd_q.addr <= next_q[pick];
                        end else begin
                            state_q <= ST_RD;
                            mem_cmd_q.addr <= src_addr[pick];
                        end
                    end
                end
                ST_DESC: begin
                    if (mem_ack) begin
                        if (didx_q == desc_last) begin
                            mem_cmd_q.valid <= 1'b0;
                            state_q <= ST_LOAD;
                        end else begin
                            didx_q <= didx_q + 3'h1;
                            dptr_q <= dptr_q + `DMA_WORD_BYTES;
                            mem_cmd_q.addr <= dptr_q + `DMA_WORD_BYTES;
                        end
                    end
                end
                ST_LOAD: begin
                    state_q <= ST_IDLE;
                end
                ST_RD: begin
                    if (mem_ack) begin
                        mem_cmd_q.we <= 1'b1;
                        mem_cmd_q.addr <= dst_addr[act_q];
                        mem_cmd_q.wdata <= mem_rdata;
                        state_q <= ST_WR;
                    end
                end
                ST_WR: begin
                    if (mem_ack) begin
                        mem_cmd_q.valid <= 1'b0;
                        mem_cmd_q.we <= 1'b0;
                        state_q <= ST_STEP;
                    end
                end
                ST_STEP: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Position counters; positions count from one so a zero count means 64K
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `DMA_NCH; i++) begin
                xpos_q[i] <= `DMA_CNT_ONE;
                ypos_q[i] <= `DMA_CNT_ONE;
            end
        end else begin
            for (int i = 0; i < `DMA_NCH; i++) begin
                if (load_c[i]) begin
                    xpos_q[i] <= `DMA_CNT_ONE;
                    ypos_q[i] <= `DMA_CNT_ONE;
                end else if (step_c[i]) begin
                    if (row_end) begin
                        xpos_q[i] <= `DMA_CNT_ONE;
                        ypos_q[i] <= ypos_q[i] + `DMA_CNT_ONE;
                    end else begin
                        xpos_q[i] <= xpos_q[i] + `DMA_CNT_ONE;
                    end
                end
            end
        end
    end

    // Run and descriptor-pending flags; software writes come last and win
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= '0;
            need_q <= '0;
        end else begin
            if (state_q == ST_LOAD) begin
                need_q[act_q] <= 1'b0;
            end
            if (in_step & buf_end) begin
                case (act_cfg.mode)
                    `DMA_MODE_STOP: run_q[act_q] <= 1'b0;
                    `DMA_MODE_LIST: begin
                        if (next_q[act_q] == `DMA_ZERO32) begin
                            run_q[act_q] <= 1'b0;
                        end else begin
                            need_q[act_q] <= 1'b1;
                        end
                    end
                    `DMA_MODE_ARRAY: need_q[act_q] <= 1'b1;
                    default: ;
                endcase
            end
            for (int i = 0; i < `DMA_NCH; i++) begin
                if (wr_cfg[i]) begin
                    run_q[i] <= reg_wdata[0];
                    need_q[i] <= reg_wdata[0] & reg_wdata[2];
                end
            end
        end
    end

    // Parameter registers: written by software or captured from a descriptor
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `DMA_NCH; i++) begin
                cfg_q[i] <= '0;
                src_start_q[i] <= `DMA_ZERO32;
                dst_start_q[i] <= `DMA_ZERO32;
                src_xmod_q[i] <= '0;
                src_ymod_q[i] <= '0;
                dst_xmod_q[i] <= '0;
                dst_ymod_q[i] <= '0;
                xcnt_q[i] <= '0;
                ycnt_q[i] <= '0;
                next_q[i] <= `DMA_ZERO32;
            end
        end else begin
            if (state_q == ST_DESC && mem_ack) begin
                if (act_cfg.mode == `DMA_MODE_ARRAY) begin
                    // Entry holds the low half; the page stays in the upper bits
                    src_start_q[act_q][15:0] <= mem_rdata[15:0];
                end else begin
                    case (didx_q)
                        `DMA_D_NEXT: next_q[act_q] <= mem_rdata;
                        `DMA_D_SRC: src_start_q[act_q] <= mem_rdata;
                        `DMA_D_DST: dst_start_q[act_q] <= mem_rdata;
                        `DMA_D_CNT: begin
                            xcnt_q[act_q] <= mem_rdata[15:0];
                            ycnt_q[act_q] <= mem_rdata[31:16];
                        end
                        `DMA_D_SMOD: begin
                            src_xmod_q[act_q] <= mem_rdata[15:0];
                            src_ymod_q[act_q] <= mem_rdata[31:16];
                        end
                        `DMA_D_DMOD: begin
                            dst_xmod_q[act_q] <= mem_rdata[15:0];
                            dst_ymod_q[act_q] <= mem_rdata[31:16];
                        end
                        default: ;
                    endcase
                end
            end
            if (state_q == ST_LOAD && act_cfg.mode == `DMA_MODE_ARRAY) begin
                next_q[act_q] <= dptr_q + `DMA_WORD_BYTES;
            end
            if (reg_wr & reg_is_ch) begin
                case (reg_off)
                    `DMA_R_CFG: cfg_q[reg_ch] <= ch_cfg_t'(reg_wdata[5:0]);
                    `DMA_R_SRC_START: src_start_q[reg_ch] <= reg_wdata;
                    `DMA_R_SRC_XMOD: src_xmod_q[reg_ch] <= reg_wdata[15:0];
                    `DMA_R_SRC_YMOD: src_ymod_q[reg_ch] <= reg_wdata[15:0];
                    `DMA_R_DST_START: dst_start_q[reg_ch] <= reg_wdata;
                    `DMA_R_DST_XMOD: dst_xmod_q[reg_ch] <= reg_wdata[15:0];
                    `DMA_R_DST_YMOD: dst_ymod_q[reg_ch] <= reg_wdata[15:0];
                    `DMA_R_XCNT: xcnt_q[reg_ch] <= reg_wdata[15:0];
                    `DMA_R_YCNT: ycnt_q[reg_ch] <= reg_wdata[15:0];
                    `DMA_R_NEXT: next_q[reg_ch] <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // External requests: each enabled edge grants a batch of transfers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_prev_q <= '0;
            for (int k = 0; k < `DMA_NEXT; k++) begin
                credit_q[k] <= '0;
            end
        end else begin
            ext_prev_q <= ext_dma_req;
            for (int k = 0; k < `DMA_NEXT; k++) begin
                // Grant and spend in one cycle both count
                credit_q[k] <= credit_q[k] +
                    (ext_edge[k] ? {8'h00, per_edge_q} : '0) -
                    ((step_c[k + `DMA_NPER] & cfg_q[k + `DMA_NPER].use_req &
                      (|credit_q[k])) ? `DMA_CNT_ONE : '0);
            end
        end
    end

    // Global control, peripheral pacing pulses and bus priority output
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            per_edge_q <= '0;
            ext_en_q <= '0;
            prio_q <= 1'b0;
            ext_prio_q <= 1'b0;
            irq_mask_q <= '0;
            periph_done_q <= '0;
        end else begin
            if (reg_wr && reg_addr == `DMA_G_EXT) begin
                per_edge_q <= reg_wdata[`DMA_EXT_CNT_HI:0];
                ext_en_q <= reg_wdata[`DMA_EXT_EN_HI:`DMA_EXT_EN_LO];
                prio_q <= reg_wdata[`DMA_EXT_PRIO_BIT];
            end
            if (reg_wr && reg_addr == `DMA_G_IRQ_MASK) begin
                irq_mask_q <= reg_wdata[`DMA_NCH-1:0];
            end
            // Raised priority only asked for while a memory channel runs
            ext_prio_q <= prio_q & (|run_q[`DMA_NCH-1:`DMA_NPER]);
            periph_done_q <= step_c[`DMA_NPER-1:0];
        end
    end

    // Sticky status: a new event in the clearing read's cycle survives
    always_comb begin
        irq_st_d = irq_st_q;
        if (reg_rd && reg_addr == `DMA_G_IRQ_ST) begin
            irq_st_d = '0;
        end
        irq_st_d = irq_st_d | irq_set;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_st_q <= '0;
            irq_q <= 1'b0;
        end else begin
            irq_st_q <= irq_st_d;
            irq_q <= |(irq_st_d & irq_mask_q);
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= `DMA_ZERO32;
        end else begin
            rdata_q <= `DMA_ZERO32;
            if (reg_rd && reg_is_ch) begin
                case (reg_off)
                    `DMA_R_CFG: rdata_q <= {run_q[reg_ch], need_q[reg_ch], 24'h000000,
                                             cfg_q[reg_ch]};
                    `DMA_R_SRC_START: rdata_q <= src_start_q[reg_ch];
                    `DMA_R_SRC_XMOD: rdata_q <= {16'h0000, src_xmod_q[reg_ch]};
                    `DMA_R_SRC_YMOD: rdata_q <= {16'h0000, src_ymod_q[reg_ch]};
                    `DMA_R_DST_START: rdata_q <= dst_start_q[reg_ch];
                    `DMA_R_DST_XMOD: rdata_q <= {16'h0000, dst_xmod_q[reg_ch]};
                    `DMA_R_DST_YMOD: rdata_q <= {16'h0000, dst_ymod_q[reg_ch]};
                    `DMA_R_XCNT: rdata_q <= {16'h0000, xcnt_q[reg_ch]};
                    `DMA_R_YCNT: rdata_q <= {16'h0000, ycnt_q[reg_ch]};
                    `DMA_R_NEXT: rdata_q <= next_q[reg_ch];
                    `DMA_R_POS: rdata_q <= {ypos_q[reg_ch], xpos_q[reg_ch]};
                    `DMA_R_CUR_SRC: rdata_q <= src_addr[reg_ch];
                    `DMA_R_CUR_DST: rdata_q <= dst_addr[reg_ch];
                    default: rdata_q <= `DMA_ZERO32;
                endcase
            end else if (reg_rd) begin
                case (reg_addr)
                    `DMA_G_IRQ_ST: rdata_q <= {28'h0000000, irq_st_q};
                    `DMA_G_IRQ_MASK: rdata_q <= {28'h0000000, irq_mask_q};
                    `DMA_G_EXT: rdata_q <= {21'h00000, prio_q, ext_en_q, per_edge_q};
                    default: rdata_q <= `DMA_ZERO32;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign mem_cmd = mem_cmd_q;
    assign periph_done = periph_done_q;
    assign ext_prio = ext_prio_q;
    assign irq = irq_q;

endmodule // dma_ctrl

// ---- test/dma_ctrl_asserts.sv ----
// Port checker for the DMA controller
`timescale 1ns/10ps
module dma_ctrl_checker
    import dma_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire mem_cmd_t mem_cmd,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic [1:0] periph_done,
    input wire logic ext_prio,
    input wire logic irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Completed write, the end of every element
    logic wr_ack;
    assign wr_ack = mem_cmd.valid && mem_cmd.we && mem_ack;
    a_cmd_hold: assert property (mem_cmd.valid && !mem_ack |=> $stable(mem_cmd))
        else $error("command moved before ack");
    a_write_gap: assert property (wr_ack |=> !mem_cmd.valid [*2])
        else $error("no idle gap after element");
    a_wdata_fwd: assert property ($rose(mem_cmd.we) |-> mem_cmd.wdata == $past(mem_rdata))
        else $error("written word differs from read word");
    a_read_first: assert property ($rose(mem_cmd.valid) |-> !mem_cmd.we)
        else $error("sequence did not begin with a read");
    a_done_cause: assert property (periph_done != 2'h0 |-> $past(wr_ack) || $past(wr_ack, 2))
        else $error("element done without a write");
    a_done_pulse: assert property (periph_done[0] |=> !periph_done[0])
        else $error("done longer than one cycle");
    a_done_single: assert property ($onehot0(periph_done))
        else $error("two elements done at once");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
        else $error("read data outside its cycle");
    c_wr_ack: cover property (wr_ack);
    c_irq: cover property ($rose(irq));
    c_prio: cover property (ext_prio);
endmodule // dma_ctrl_checker

bind dma_ctrl dma_ctrl_checker chk_i (.*);

// ---- test/dma_mem_model.sv ----
// Word memory answering the controller's command port
`timescale 1ns/10ps
module dma_mem_model
    import dma_pkg::*;
(
    input wire logic clk,
    input wire mem_cmd_t mem_cmd,
    input wire logic slow,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
    logic [31:0] mem [256];
    logic [1:0] wait_q;
    // Tagged contents, so a moved word shows its source
    initial begin
        foreach (mem[i]) mem[i] = 32'hA0000000 | 32'(i);
        mem_ack = 1'h0;
        mem_rdata = 32'h00000000;
        wait_q = 2'h0;
    end
    // Stale data inverted after ack, so nothing leans on it
    always @(posedge clk) begin
        if (mem_ack) begin
            mem_ack <= 1'h0;
            mem_rdata <= ~mem_rdata;
        end else if (mem_cmd.valid && wait_q != (slow ? 2'h2 : 2'h0)) begin
            wait_q <= wait_q + 2'h1;
        end else if (mem_cmd.valid) begin
            mem_ack <= 1'h1;
            wait_q <= 2'h0;
            if (mem_cmd.we) mem[mem_cmd.addr[9:2]] <= mem_cmd.wdata;
            else mem_rdata <= mem[mem_cmd.addr[9:2]];
        end
    end
endmodule // dma_mem_model

// ---- test/multichannel_dma_controller_bench.sv ----
// Self-checking bench for the DMA controller
`timescale 1ns/10ps
module multichannel_dma_controller_bench
    import dma_pkg::*;
();
    logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, slow = 0, irq, ext_prio, mem_ack;
    logic seen_p = 0, seen_d = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, rdv, reg_rdata, mem_rdata;
    logic [1:0] periph_req = 2'h0, periph_done, ext_dma_req = 2'h0;
    mem_cmd_t mem_cmd;
    int mismatches = 0, cmp_count = 0;
    // List descriptor: next, src, dst, {ycnt,xcnt}, {src ymod,xmod}, {dst ymod,xmod}
    logic [31:0] desc [6] = '{32'h0, 32'h40, 32'h380, 32'h00020002, 32'hFFFF0002, 32'h00010001};
    // Address, word written, word read back
    logic [71:0] rows [4] = '{72'h02FFFF800000008000, 72'h170001FFFF0000FFFF,
        72'h81FFFFFFFF0000000F, 72'hC0FFFFFFFF00000000};
    dma_ctrl uut (.*);
    dma_mem_model ram (.*);
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (ext_prio) seen_p <= 1'h1;
        if (periph_done[0]) seen_d <= 1'h1;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One register cycle; read data kept in rdv
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk);
        {reg_wr, reg_rd} <= 2'h0;
        #1 rdv = reg_rdata;
    endtask
    task edge_req;
        @(posedge clk) ext_dma_req <= 2'h1;
        @(posedge clk) ext_dma_req <= 2'h0;
    endtask
    task final_report;
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #20000 mismatches++;
        final_report;
    end
    initial begin
        repeat (12) @(posedge clk);
        chk(32'({mem_cmd.valid, irq}), 32'h0);
        reset_n <= 1'h1;
        foreach (rows[i]) begin
            acc(1, rows[i][71:64], rows[i][63:32]);
            acc(0, rows[i][71:64], 32'h0);
            chk(rdv, rows[i][31:0]);
        end
        // Channel 0 holds off until its peripheral asks
        acc(1, 8'h07, 32'h1);
        acc(1, 8'h00, 32'h21);
        repeat (30) @(posedge clk);
        chk(32'(seen_d), 32'h0);
        periph_req <= 2'h1;
        repeat (30) @(posedge clk);
        chk(32'(seen_d), 32'h1);
        // Channel 2: three words, two per external edge, slow memory
        slow <= 1'h1;
        acc(1, 8'h82, 32'h502);
        acc(1, 8'h81, 32'h4);
        acc(1, 8'h21, 32'h10);
        acc(1, 8'h22, 32'h1);
        acc(1, 8'h24, 32'h300);
        acc(1, 8'h25, 32'h1);
        acc(1, 8'h27, 32'h3);
        acc(1, 8'h20, 32'h21);
        edge_req;
        repeat (60) @(posedge clk);
        chk(ram.mem[193], 32'hA0000005);
        chk(ram.mem[194], 32'hA00000C2);
        edge_req;
        for (int i = 0; i < 99 && irq !== 1'h1; i++) @(posedge clk);
        chk(ram.mem[194], 32'hA0000006);
        chk(32'(seen_p), 32'h1);
        acc(0, 8'h80, 32'h0);
        chk(rdv, 32'h5);
        acc(0, 8'h80, 32'h0);
        chk(rdv | 32'(irq), 32'h0);
        // Channel 3: one 2-D list descriptor; outer step -1 splits interleaved words
        foreach (desc[i]) ram.mem[128 + i] = desc[i];
        acc(1, 8'h39, 32'h200);
        acc(1, 8'h30, 32'hD);
        repeat (150) @(posedge clk);
        chk(ram.mem[225], 32'hA0000012);
        chk(ram.mem[226], 32'hA0000011);
        chk(ram.mem[227], 32'hA0000013);
        acc(0, 8'h30, 32'h0);
        chk(rdv, 32'hD);
        acc(0, 8'h80, 32'h0);
        chk(rdv, 32'h8);
        // Channel 1 autobuffer: keeps running, flags every buffer end
        acc(1, 8'h17, 32'h2);
        acc(1, 8'h10, 32'h3);
        repeat (60) @(posedge clk);
        acc(0, 8'h80, 32'h0);
        chk(rdv, 32'h2);
        repeat (60) @(posedge clk);
        acc(0, 8'h10, 32'h0);
        chk(rdv, 32'h80000003);
        acc(0, 8'h80, 32'h0);
        chk(rdv, 32'h2);
        final_report;
    end
endmodule // multichannel_dma_controller_bench
